// ===== inc/pwm_out_pkg.sv
// Constants shared by the enhanced PWM output-control block
package pwm_out_pkg;
   // Register byte offsets on the bus
   localparam logic [4:0] OFS_UNIT_CTRL = 5'h00;
   localparam logic [4:0] OFS_SHD_CTRL = 5'h04;
   localparam logic [4:0] OFS_STEER_CTRL = 5'h08;
   localparam logic [4:0] OFS_RST_DB_CTRL = 5'h0c;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   // Reset values
   localparam logic [7:0] RST_UNIT_CTRL = 8'h00;
   localparam logic [7:0] RST_SHD_CTRL = 8'h00;
   localparam logic [7:0] RST_STEER_CTRL = 8'h01;
   localparam logic [7:0] RST_RST_DB_CTRL = 8'h00;
   // Unit control fields
   localparam int MODE_LSB = 0;
   localparam int MODE_POL_AC = 1;
   localparam int MODE_POL_BD = 0;
   localparam int MODE_SEL_LSB = 2;
   localparam int BRIDGE_LSB = 6;
   localparam logic [1:0] MODE_PWM = 2'h3;
   localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
   localparam logic [1:0] BRIDGE_FULL_FWD = 2'h1;
   localparam logic [1:0] BRIDGE_HALF = 2'h2;
   localparam logic [1:0] BRIDGE_FULL_REV = 2'h3;
   // Shutdown control fields
   localparam int SHD_FLAG_BIT = 7;
   localparam int SHD_SRC_LSB = 4;
   localparam int SHD_AC_LSB = 2;
   localparam int SHD_BD_LSB = 0;
   localparam int SRC_COMP1 = 0;
   localparam int SRC_COMP2 = 1;
   localparam int SRC_FAULT = 2;
   localparam logic [1:0] SHD_DRIVE_LOW = 2'h0;
   localparam logic [1:0] SHD_DRIVE_HIGH = 2'h1;
   localparam int SHD_TRISTATE_BIT = 1;
   // Steering control fields
   localparam int STEER_SYNC_BIT = 4;
   // Restart and dead-band control fields
   localparam int RESTART_EN_BIT = 7;
   localparam int DB_COUNT_W = 7;
   // Status register fields
   localparam int STAT_TPF_BIT = 0;
   localparam int STAT_LEVEL_BIT = 1;
   localparam int STAT_RUN_BIT = 2;
   localparam int STAT_STEER_LSB = 4;
   // One instruction cycle is four oscillator periods
   localparam int TOSC_PER_TCY = 4;
   typedef enum logic [1:0] {START_IDLE, START_FIRST, START_RUN} startup_t;
endpackage

// ===== logic/deadband_delay.sv
// Dead-band delay for one half-bridge output
`timescale 1ns/1ns
module deadband_delay #(
   parameter int DB_W = 7
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Timing
   input wire logic tcy_tick,
   input wire logic [DB_W-1:0] delay,
   // Request and delayed output
   input wire logic req,
   output logic out_active
);
   logic [DB_W-1:0] cnt_ff, nxt_cnt;
   logic act_ff, nxt_act;
   logic req_ff, nxt_req;

   if (DB_W < 1) begin : g_chk
      $error("deadband_delay: DB_W must be at least 1");
   end

   // Delay only the rising request; the falling one is passed at once
   always_comb begin
      nxt_req = req;
      nxt_cnt = cnt_ff;
      nxt_act = act_ff;
      if (!req) begin
         nxt_cnt = '0;
         nxt_act = 1'b0; // RULE_04
      end else if (!req_ff) begin
         nxt_cnt = '0; // RULE_20
         nxt_act = (delay == '0);
      end else if (!act_ff && tcy_tick) begin
         // One extra tick covers the partial first cycle, so the band is never short
         if (cnt_ff >= delay) begin
            nxt_act = 1'b1; // RULE_20
         end else begin
            nxt_cnt = cnt_ff + 1'b1; // RULE_05
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         act_ff <= 1'b0;
         req_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         act_ff <= nxt_act;
         req_ff <= nxt_req;
      end
   end

   assign out_active = act_ff;

   property p_db_fall;
      @(posedge clk_sys) disable iff (!rst_n) !req |=> !act_ff;
   endproperty
   a_db_fall: assert property (p_db_fall) else $error("output stayed active"); // RULE_04

   property p_db_hold;
      @(posedge clk_sys) disable iff (!rst_n) (req && !req_ff && delay != '0) |=> !act_ff;
   endproperty
   a_db_hold: assert property (p_db_hold) else $error("dead band skipped"); // RULE_20

   property p_db_rise;
      @(posedge clk_sys) disable iff (!rst_n) $rose(act_ff) |-> $past(req) && (cnt_ff >= delay);
   endproperty
   a_db_rise: assert property (p_db_rise) else $error("early activation"); // RULE_05
endmodule // deadband_delay

// ===== logic/pwm_output_control.sv
// Enhanced PWM output control: shutdown, restart, dead band, steering
//
// Function
// RULE_01: Auto restart only when restart enable set
// RULE_02: Restart on: flag held while source asserted
// RULE_03: Restart on: flag cleared when source goes
// RULE_04: Dead band only on inactive-to-active edge
// RULE_05: Dead band from low seven bits, Tcy
// RULE_06: Steering when mode 11, bridge config 00
// RULE_07: Same PWM on every steer-enabled pin
// RULE_08: Steering polarity from low mode bits
// RULE_09: Shutdown only touches enabled steered pins
// RULE_10: Sync 0: steer update right after write
// RULE_11: Sync 1: steer update at period start
// RULE_12: Bridge polarity per pair A/C, B/D
// RULE_13: Firmware sets polarity before enabling drivers
// RULE_14: Firmware waits one cycle before drivers
// RULE_15: Timer flag set as second period begins
// RULE_16: Shutdown sets flag, pins forced asynchronously
// RULE_17: Resume output only at next period
// RULE_18: Flag writes ignored while source present
// RULE_19: Restart off: flag kept until firmware clears
// RULE_20: Per-output dead-band counter restarts per request
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
module pwm_output_control #(
   parameter int DB_W = 7
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Period base and modulated signal
   input wire logic period_start,
   input wire logic pwm_in,
   // Shutdown sources
   input wire logic fault_input_n,
   input wire logic comp1_out,
   input wire logic comp2_out,
   // Output pins
   output logic out_a,
   output logic out_a_oe_n,
   output logic out_b,
   output logic out_b_oe_n,
   output logic out_c,
   output logic out_c_oe_n,
   output logic out_d,
   output logic out_d_oe_n,
   // Status
   output logic timer_period_flag
);
   localparam int TCY_W = $clog2(pwm_out_pkg::TOSC_PER_TCY);

   if (DB_W != pwm_out_pkg::DB_COUNT_W) begin : g_chk
      $error("pwm_output_control: DB_W must match the dead-band field");
   end

   // Bus slave
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] unit_ctrl_ff, nxt_unit_ctrl;
   logic [7:0] shd_ctrl_ff, nxt_shd_ctrl;
   logic [7:0] steer_ctrl_ff, nxt_steer_ctrl;
   logic [7:0] rst_db_ctrl_ff, nxt_rst_db_ctrl;
   logic [3:0] steer_eff_ff, nxt_steer_eff;
   logic tpf_ff, nxt_tpf;
   logic run_ff, nxt_run;
   logic [TCY_W-1:0] tcy_ff, nxt_tcy;
   pwm_out_pkg::startup_t start_ff, nxt_start;
   logic do_wr, lane0;
   logic wr_unit, wr_shd, wr_steer, wr_rst_db, wr_stat;
   logic [7:0] stat_val;

   // Decoded controls
   logic [3:0] unit_mode_field;
   logic [1:0] bridge_output_config;
   logic [2:0] shutdown_source_select;
   logic [1:0] pair_ac_shutdown_state, pair_bd_shutdown_state;
   logic shutdown_event_flag, auto_restart_enable, steer_sync_select;
   logic [DB_W-1:0] deadband_count;
   logic pwm_mode, single_mode, half_mode;
   logic shd_level, shd_any, tcy_tick;
   logic [1:0] db_req, db_act;
   logic [3:0] pin_act, pin_en, pin_pol, pin_lvl, pin_o, pin_oe_n;

   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign avs_readdata = rdata_ff;
   assign do_wr = avs_write && ack_ff;
   assign lane0 = avs_byteenable[0];
   assign wr_unit = do_wr && lane0 && (avs_address == pwm_out_pkg::OFS_UNIT_CTRL);
   assign wr_shd = do_wr && lane0 && (avs_address == pwm_out_pkg::OFS_SHD_CTRL);
   assign wr_steer = do_wr && lane0 && (avs_address == pwm_out_pkg::OFS_STEER_CTRL);
   assign wr_rst_db = do_wr && lane0 && (avs_address == pwm_out_pkg::OFS_RST_DB_CTRL);
   assign wr_stat = do_wr && lane0 && (avs_address == pwm_out_pkg::OFS_STATUS);

   assign unit_mode_field = unit_ctrl_ff[pwm_out_pkg::MODE_LSB +: 4];
   assign bridge_output_config = unit_ctrl_ff[pwm_out_pkg::BRIDGE_LSB +: 2];
   assign shutdown_event_flag = shd_ctrl_ff[pwm_out_pkg::SHD_FLAG_BIT];
   assign shutdown_source_select = shd_ctrl_ff[pwm_out_pkg::SHD_SRC_LSB +: 3];
   assign pair_ac_shutdown_state = shd_ctrl_ff[pwm_out_pkg::SHD_AC_LSB +: 2];
   assign pair_bd_shutdown_state = shd_ctrl_ff[pwm_out_pkg::SHD_BD_LSB +: 2];
   assign steer_sync_select = steer_ctrl_ff[pwm_out_pkg::STEER_SYNC_BIT];
   assign auto_restart_enable = rst_db_ctrl_ff[pwm_out_pkg::RESTART_EN_BIT]; // RULE_01
   assign deadband_count = rst_db_ctrl_ff[DB_W-1:0]; // RULE_05

   assign pwm_mode = (unit_mode_field[3:2] == pwm_out_pkg::MODE_PWM);
   assign single_mode = pwm_mode && (bridge_output_config == pwm_out_pkg::BRIDGE_SINGLE); // RULE_06
   assign half_mode = pwm_mode && (bridge_output_config == pwm_out_pkg::BRIDGE_HALF);

   // Shutdown level is a pure level from the pins, so it forces outputs with no clock
   assign shd_level = (shutdown_source_select[pwm_out_pkg::SRC_COMP1] && comp1_out)
                   || (shutdown_source_select[pwm_out_pkg::SRC_COMP2] && comp2_out)
                   || (shutdown_source_select[pwm_out_pkg::SRC_FAULT] && !fault_input_n);
   assign shd_any = shd_level || shutdown_event_flag; // RULE_16

   assign stat_val = {steer_eff_ff, 1'b0, run_ff, shd_level, tpf_ff};

   // Register file and bus answer
   always_comb begin
      nxt_ack = (avs_read || avs_write) && !ack_ff;
      nxt_rdata = '0;
      if ((avs_read || avs_write) && !ack_ff) begin
         case (avs_address)
            pwm_out_pkg::OFS_UNIT_CTRL: nxt_rdata = {24'h000000, unit_ctrl_ff};
            pwm_out_pkg::OFS_SHD_CTRL: nxt_rdata = {24'h000000, shd_ctrl_ff};
            pwm_out_pkg::OFS_STEER_CTRL: nxt_rdata = {24'h000000, steer_ctrl_ff};
            pwm_out_pkg::OFS_RST_DB_CTRL: nxt_rdata = {24'h000000, rst_db_ctrl_ff};
            pwm_out_pkg::OFS_STATUS: nxt_rdata = {24'h000000, stat_val};
            default: nxt_rdata = '0;
         endcase
      end
      nxt_unit_ctrl = wr_unit ? avs_writedata[7:0] : unit_ctrl_ff;
      nxt_rst_db_ctrl = wr_rst_db ? avs_writedata[7:0] : rst_db_ctrl_ff;
      nxt_steer_ctrl = wr_steer ? {3'h0, avs_writedata[4:0]} : steer_ctrl_ff;
      nxt_shd_ctrl = shd_ctrl_ff;
      if (wr_shd) begin
         nxt_shd_ctrl[6:0] = avs_writedata[6:0];
         if (!shd_level) begin
            nxt_shd_ctrl[pwm_out_pkg::SHD_FLAG_BIT] =
               avs_writedata[pwm_out_pkg::SHD_FLAG_BIT]; // RULE_18
         end
      end
      // Hardware set beats any clear in the same cycle
      if (shd_level) begin
         nxt_shd_ctrl[pwm_out_pkg::SHD_FLAG_BIT] = 1'b1; // RULE_02
      end else if (auto_restart_enable) begin
         nxt_shd_ctrl[pwm_out_pkg::SHD_FLAG_BIT] = 1'b0; // RULE_03
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
         unit_ctrl_ff <= pwm_out_pkg::RST_UNIT_CTRL;
         shd_ctrl_ff <= pwm_out_pkg::RST_SHD_CTRL;
         steer_ctrl_ff <= pwm_out_pkg::RST_STEER_CTRL;
         rst_db_ctrl_ff <= pwm_out_pkg::RST_RST_DB_CTRL;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         unit_ctrl_ff <= nxt_unit_ctrl;
         shd_ctrl_ff <= nxt_shd_ctrl;
         steer_ctrl_ff <= nxt_steer_ctrl;
         rst_db_ctrl_ff <= nxt_rst_db_ctrl;
      end
   end

   // Steering, restart, start-up and instruction-cycle timing
   always_comb begin
      nxt_steer_eff = steer_eff_ff;
      if (wr_steer && !avs_writedata[pwm_out_pkg::STEER_SYNC_BIT]) begin
         nxt_steer_eff = avs_writedata[3:0]; // RULE_10
      end else if (period_start && steer_sync_select) begin
         nxt_steer_eff = steer_ctrl_ff[3:0]; // RULE_11
      end
      nxt_run = run_ff;
      if (shd_any || !pwm_mode) begin
         nxt_run = 1'b0;
      end else if (period_start) begin
         nxt_run = 1'b1; // RULE_17
      end
      nxt_start = start_ff;
      nxt_tpf = tpf_ff;
      if (wr_stat && avs_writedata[pwm_out_pkg::STAT_TPF_BIT]) begin
         nxt_tpf = 1'b0;
      end
      case (start_ff)
         pwm_out_pkg::START_IDLE: begin
            if (pwm_mode && period_start) begin
               nxt_start = pwm_out_pkg::START_FIRST;
            end
         end
         pwm_out_pkg::START_FIRST, pwm_out_pkg::START_RUN: begin
            if (!pwm_mode) begin
               nxt_start = pwm_out_pkg::START_IDLE;
            end else if (period_start) begin
               nxt_start = pwm_out_pkg::START_RUN;
               nxt_tpf = 1'b1; // RULE_15
            end
         end
         default: nxt_start = pwm_out_pkg::START_IDLE;
      endcase
      nxt_tcy = tcy_ff + 1'b1;
      if (tcy_tick) begin
         nxt_tcy = '0;
      end
   end

   assign tcy_tick = (tcy_ff == TCY_W'(pwm_out_pkg::TOSC_PER_TCY - 1)); // RULE_05

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         steer_eff_ff <= pwm_out_pkg::RST_STEER_CTRL[3:0];
         run_ff <= 1'b0;
         start_ff <= pwm_out_pkg::START_IDLE;
         tpf_ff <= 1'b0;
         tcy_ff <= '0;
      end else begin
         steer_eff_ff <= nxt_steer_eff;
         run_ff <= nxt_run;
         start_ff <= nxt_start;
         tpf_ff <= nxt_tpf;
         tcy_ff <= nxt_tcy;
      end
   end

   assign timer_period_flag = tpf_ff;

   // Half-bridge primary and complementary outputs, each with its own dead band
   assign db_req = {!pwm_in && half_mode, pwm_in && half_mode};
   for (genvar i = 0; i < 2; i++) begin : g_db
      deadband_delay #(.DB_W(DB_W)) u_db (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .tcy_tick(tcy_tick),
         .delay(deadband_count),
         .req(db_req[i]),
         .out_active(db_act[i])
      ); // RULE_20
   end

   // Pin order in vectors is {d, c, b, a}
   always_comb begin
      pin_act = '0;
      pin_en = '0;
      if (pwm_mode) begin
         case (bridge_output_config)
            pwm_out_pkg::BRIDGE_SINGLE: begin
               pin_act = {4{pwm_in}}; // RULE_07
               pin_en = steer_eff_ff; // RULE_09
            end
            pwm_out_pkg::BRIDGE_HALF: begin
               pin_act = {2'b00, db_act[1], db_act[0]}; // RULE_04
               pin_en = 4'h3;
            end
            pwm_out_pkg::BRIDGE_FULL_FWD: begin
               pin_act = {pwm_in, 2'b00, 1'b1};
               pin_en = 4'hf;
            end
            pwm_out_pkg::BRIDGE_FULL_REV: begin
               pin_act = {1'b0, 1'b1, pwm_in, 1'b0};
               pin_en = 4'hf;
            end
            default: pin_en = '0;
         endcase
      end
   end

   // Polarity is per pair in every PWM mode, steering included
   assign pin_pol = {unit_mode_field[pwm_out_pkg::MODE_POL_BD],
                     unit_mode_field[pwm_out_pkg::MODE_POL_AC],
                     unit_mode_field[pwm_out_pkg::MODE_POL_BD],
                     unit_mode_field[pwm_out_pkg::MODE_POL_AC]}; // RULE_08 RULE_12
   // Until the next period after a restart the pins sit at their inactive level
   assign pin_lvl = (run_ff ? pin_act : 4'h0) ^ pin_pol;

   for (genvar p = 0; p < 4; p++) begin : g_pin
      logic [1:0] sst;
      assign sst = (p % 2 == 0) ? pair_ac_shutdown_state : pair_bd_shutdown_state;
      always_comb begin
         pin_o[p] = 1'b0;
         pin_oe_n[p] = 1'b1;
         if (pin_en[p]) begin
            if (shd_any) begin
               pin_o[p] = (sst == pwm_out_pkg::SHD_DRIVE_HIGH); // RULE_16
               pin_oe_n[p] = sst[pwm_out_pkg::SHD_TRISTATE_BIT];
            end else begin
               pin_o[p] = pin_lvl[p];
               pin_oe_n[p] = 1'b0;
            end
         end
      end
   end

   assign {out_d, out_c, out_b, out_a} = pin_o;
   assign {out_d_oe_n, out_c_oe_n, out_b_oe_n, out_a_oe_n} = pin_oe_n;

   sequence s_level_gone;
      !shd_level && shutdown_event_flag;
   endsequence

   property p_restart_clear;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_level_gone and auto_restart_enable) |=> !shutdown_event_flag;
   endproperty
   a_restart_clear: assert property (p_restart_clear) else $error("flag not auto cleared"); // RULE_03

   property p_flag_kept;
      @(posedge clk_sys) disable iff (!rst_n)
         (s_level_gone and !auto_restart_enable and !wr_shd) |=> shutdown_event_flag;
   endproperty
   a_flag_kept: assert property (p_flag_kept) else $error("flag lost without restart"); // RULE_19

   property p_flag_set;
      @(posedge clk_sys) disable iff (!rst_n) shd_level [*2] |-> shutdown_event_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not held by level"); // RULE_02

   property p_write_ignored;
      @(posedge clk_sys) disable iff (!rst_n) (shd_level && wr_shd) |=> shutdown_event_flag;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("flag write took effect"); // RULE_18

   property p_async_force;
      @(posedge clk_sys) disable iff (!rst_n)
         (shd_level && pin_en[0] && pair_ac_shutdown_state == pwm_out_pkg::SHD_DRIVE_HIGH)
         |-> (out_a && !out_a_oe_n);
   endproperty
   a_async_force: assert property (p_async_force) else $error("pin A not forced"); // RULE_16

   property p_resume_period;
      @(posedge clk_sys) disable iff (!rst_n) $rose(run_ff) |-> $past(period_start);
   endproperty
   a_resume_period: assert property (p_resume_period) else $error("resume off period"); // RULE_17

   property p_steer_now;
      @(posedge clk_sys) disable iff (!rst_n)
         (wr_steer && !avs_writedata[pwm_out_pkg::STEER_SYNC_BIT])
         |=> (steer_eff_ff == $past(avs_writedata[3:0]));
   endproperty
   a_steer_now: assert property (p_steer_now) else $error("steer not immediate"); // RULE_10

   property p_steer_sync;
      @(posedge clk_sys) disable iff (!rst_n)
         $changed(steer_eff_ff) |-> $past(period_start) || $past(wr_steer);
   endproperty
   a_steer_sync: assert property (p_steer_sync) else $error("steer changed mid period"); // RULE_11

   sequence s_two_periods;
      (start_ff == pwm_out_pkg::START_FIRST) && period_start && pwm_mode;
   endsequence

   property p_tpf;
      @(posedge clk_sys) disable iff (!rst_n) s_two_periods |=> tpf_ff;
   endproperty
   a_tpf: assert property (p_tpf) else $error("timer flag missed"); // RULE_15

   property p_steer_pin;
      @(posedge clk_sys) disable iff (!rst_n)
         (single_mode && run_ff && !shd_any && steer_eff_ff[1])
         |-> (out_b == (pwm_in ^ unit_mode_field[pwm_out_pkg::MODE_POL_BD])) && !out_b_oe_n;
   endproperty
   a_steer_pin: assert property (p_steer_pin) else $error("steered pin wrong"); // RULE_07

   property p_unsteered;
      @(posedge clk_sys) disable iff (!rst_n)
         (single_mode && !steer_eff_ff[2]) |-> out_c_oe_n && !out_c;
   endproperty
   a_unsteered: assert property (p_unsteered) else $error("unsteered pin touched"); // RULE_09
endmodule // pwm_output_control

// ===== bench/power_stage_model.sv
// Switch driver stage model on the four output pins
`timescale 1ns/1ns
module power_stage_model (
   // Pin drive from the block
   input wire logic [3:0] drv,
   input wire logic [3:0] drv_oe_n,
   // Level seen by each switch stage
   output logic [3:0] pin
);
   // A released pin falls to the board pull-down, which keeps its switch off
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = drv_oe_n[i] ? 1'b0 : drv[i];
      end
   end
endmodule // power_stage_model

// ===== bench/enhanced_pwm_output_control_test.sv
// Self-checking bench for the enhanced PWM output-control block
`timescale 1ns/1ns
module enhanced_pwm_output_control_test;
   logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, period_start, pwm_in;
   logic fault_input_n, comp1_out, comp2_out, timer_period_flag;
   logic out_a, out_b, out_c, out_d, out_a_oe_n, out_b_oe_n, out_c_oe_n, out_d_oe_n;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, be_lane, outs, oen, pin;
   logic [7:0] rd;
   int error_cnt, total_checks, cyc;
   assign outs = {out_d, out_c, out_b, out_a};
   assign oen = {out_d_oe_n, out_c_oe_n, out_b_oe_n, out_a_oe_n};

   pwm_output_control DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .period_start(period_start), .pwm_in(pwm_in),
      .fault_input_n(fault_input_n), .comp1_out(comp1_out), .comp2_out(comp2_out),
      .out_a(out_a), .out_a_oe_n(out_a_oe_n), .out_b(out_b), .out_b_oe_n(out_b_oe_n),
      .out_c(out_c), .out_c_oe_n(out_c_oe_n), .out_d(out_d), .out_d_oe_n(out_d_oe_n),
      .timer_period_flag(timer_period_flag));
   power_stage_model u_stage (.drv(outs), .drv_oe_n(oen), .pin(pin));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be_lane;
      avs_write <= wr;
      avs_read <= !wr;
      // Waitrequest and read data are taken at the same rising edge
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      chk("waitrequest", 8'h00, {7'h00, avs_waitrequest});
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, rd);
   endtask

   task automatic pins(input logic [3:0] eo, input logic [3:0] en);
      @(negedge clk_sys);
      chk("out", {4'h0, eo}, {4'h0, outs});
      chk("oe_n", {4'h0, en}, {4'h0, oen});
      chk("pin", {4'h0, eo & ~en}, {4'h0, pin});
   endtask

   task automatic period;
      @(posedge clk_sys);
      period_start <= 1'b1;
      @(posedge clk_sys);
      period_start <= 1'b0;
   endtask

   task automatic lat(input int i, input logic v, output int n);
      n = 0;
      @(negedge clk_sys);
      while (outs[i] !== v && n < 600) begin
         n++;
         @(negedge clk_sys);
      end
   endtask

   task automatic t_reset;
      rdchk("unit", 5'h00, pwm_out_pkg::RST_UNIT_CTRL);
      rdchk("shd", 5'h04, pwm_out_pkg::RST_SHD_CTRL);
      rdchk("steer", 5'h08, pwm_out_pkg::RST_STEER_CTRL);
      rdchk("rst_db", 5'h0c, pwm_out_pkg::RST_RST_DB_CTRL);
      be_lane = 4'h0;
      wr(5'h08, 8'h1f);
      be_lane = 4'h1;
      rdchk("steer_no_lane", 5'h08, pwm_out_pkg::RST_STEER_CTRL);
      wr(5'h14, 8'hff);
      rdchk("unmapped", 5'h14, 8'h00);
   endtask

   task automatic t_start;
      @(posedge clk_sys);
      pwm_in <= 1'b1;
      wr(5'h00, 8'h0c);
      pins(4'h0, 4'he);
      period;
      @(negedge clk_sys);
      chk("tpf_first", 8'h00, {7'h00, timer_period_flag});
      period;
      @(negedge clk_sys);
      chk("tpf_second", 8'h01, {7'h00, timer_period_flag});
      wr(5'h10, 8'h01);
      @(negedge clk_sys);
      chk("tpf_clear", 8'h00, {7'h00, timer_period_flag});
   endtask

   task automatic t_steer;
      wr(5'h08, 8'h0f);
      pins(4'hf, 4'h0);
      wr(5'h08, 8'h00);
      wr(5'h00, 8'h0e);
      wr(5'h08, 8'h0f);
      pins(4'ha, 4'h0);
      wr(5'h08, 8'h00);
      wr(5'h00, 8'h0c);
      wr(5'h08, 8'h0f);
      wr(5'h08, 8'h11);
      pins(4'hf, 4'h0);
      period;
      pins(4'h1, 4'he);
   endtask

   task automatic t_shut;
      wr(5'h08, 8'h03);
      wr(5'h04, 8'h16);
      @(posedge clk_sys);
      pwm_in <= 1'b0;
      pins(4'h0, 4'hc);
      @(posedge clk_sys);
      comp1_out <= 1'b1;
      pins(4'h1, 4'he);
      rdchk("flag_set", 5'h04, 8'h96);
      wr(5'h04, 8'h16);
      rdchk("flag_write_held", 5'h04, 8'h96);
      @(posedge clk_sys);
      comp1_out <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdchk("flag_kept", 5'h04, 8'h96);
      pins(4'h1, 4'he);
      wr(5'h04, 8'h16);
      rdchk("flag_cleared", 5'h04, 8'h16);
      @(posedge clk_sys);
      pwm_in <= 1'b1;
      pins(4'h0, 4'hc);
      period;
      pins(4'h3, 4'hc);
   endtask

   task automatic t_auto;
      wr(5'h0c, 8'h80);
      wr(5'h04, 8'h41);
      @(posedge clk_sys);
      fault_input_n <= 1'b0;
      pins(4'h2, 4'hc);
      repeat (4) @(posedge clk_sys);
      rdchk("auto_flag_held", 5'h04, 8'hc1);
      rdchk("status_shut", 5'h10, 8'h33);
      @(posedge clk_sys);
      fault_input_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rdchk("auto_flag_clear", 5'h04, 8'h41);
      pins(4'h0, 4'hc);
      period;
      pins(4'h3, 4'hc);
   endtask

   // Rising edge of a leg waits the dead band; falling edge does not
   task automatic t_half;
      int na, nb, lo, hi, db;
      wr(5'h00, 8'h8c);
      for (int k = 0; k < 2; k++) begin
         db = k * 3;
         lo = (db == 0) ? 1 : 4 * db;
         hi = (db == 0) ? 1 : 4 * db + 5;
         wr(5'h0c, db[7:0]);
         period;
         @(posedge clk_sys);
         pwm_in <= 1'b0;
         repeat (40) @(posedge clk_sys);
         chk("cd_oe_n", 8'h03, {6'h00, out_d_oe_n, out_c_oe_n});
         @(posedge clk_sys);
         pwm_in <= 1'b1;
         fork
            lat(0, 1'b1, na);
            lat(1, 1'b0, nb);
         join
         chk("a_rise_window", 8'h01, {7'h00, na >= lo && na <= hi});
         chk("b_fall", 8'h01, nb[7:0]);
         repeat (40) @(posedge clk_sys);
         pwm_in <= 1'b0;
         fork
            lat(0, 1'b0, na);
            lat(1, 1'b1, nb);
         join
         chk("a_fall", 8'h01, na[7:0]);
         chk("b_rise_window", 8'h01, {7'h00, nb >= lo && nb <= hi});
      end
   endtask

   // Full bridge: one leg held active, the opposite one modulated
   task automatic t_full;
      @(posedge clk_sys);
      pwm_in <= 1'b1;
      wr(5'h00, 8'h4c);
      pins(4'h9, 4'h0);
      wr(5'h00, 8'hcc);
      pins(4'h6, 4'h0);
   endtask

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h1;
      be_lane = 4'h1;
      period_start = 1'b0;
      pwm_in = 1'b0;
      fault_input_n = 1'b1;
      comp1_out = 1'b0;
      comp2_out = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset;
      t_start;
      t_steer;
      t_shut;
      t_auto;
      t_half;
      t_full;
      test_done();
   end
endmodule // enhanced_pwm_output_control_test
